// ===== acs_conv_seq.sv
`timescale 1ns/10ps
`default_nettype none

module acs_conv_seq (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       hw_trig_in,
  input  wire logic       alt_clk_in,
  input  wire logic       stop_mode_in,
  input  wire logic       comparator_in,
  output logic [7:0]      rdata_out,
  output logic            irq_out,
  output logic            active_out,
  output logic            sample_out,
  output logic [4:0]      channel_out,
  output logic            async_clk_en_out,
  output logic [11:0]     dac_code_out
);
  typedef struct packed {
    acs_pkg::acs_state_t st;
    logic                conversion_complete_flag;
    logic                complete_interrupt_enable;
    logic                cont;
    logic [4:0]          ch;
    logic                hwt;
    logic                compare_function_enable;
    logic                compare_greater_select;
    logic [7:0]          cfg;
    logic [7:0]          cvh;
    logic [7:0]          cvl;
    logic [7:0]          rh;
    logic [7:0]          rl;
    logic [7:0]          rdata;
    logic                rh_read;
    logic [7:0]          cnt;
    logic                hw_s1;
    logic                hw_s2;
    logic                hw_prev;
    logic                alt_s1;
    logic                alt_s2;
    logic                alt_prev;
    logic                half;
    logic [3:0]          acnt;
    logic                atick;
    logic                aen;
    logic                sar_start;
    logic                sampling;
    logic                active;
    logic                irq;
  } acs_core_t;

  acs_core_t   s;
  acs_core_t   next_s;
  logic [1:0]  clk_sel;
  logic [1:0]  mode;
  logic        src_tick;
  logic        converter_clock;
  logic [11:0] code;
  logic        sar_done;
  logic [8:0]  r8;
  logic [10:0] r10;
  logic [11:0] res;
  logic [12:0] diff;
  logic        cmp_ok;
  logic [11:0] val;
  logic [15:0] stored;
  logic        blocked;
  logic        can_start;
  logic        hw_start;
  logic [7:0]  samp_last;
  logic        set_conversion_complete_flag;
  logic [7:0]  rd_mux;

  // first state of a conversion: warm the internal clock when it is cold
  function automatic acs_pkg::acs_state_t first_state(input logic [1:0] sel,
                                                       input logic warm);
    first_state = (sel == acs_pkg::CLK_ASYNC && !warm) ? acs_pkg::ST_WARM
                                                        : acs_pkg::ST_SAMPLE;
  endfunction

  // configuration decode
  assign clk_sel = s.cfg[acs_pkg::CFG_CLK +: 2];
  assign mode = s.cfg[acs_pkg::CFG_MODE +: 2];
  assign samp_last = s.cfg[acs_pkg::CFG_LSMP] ? acs_pkg::SAMP_LONG_LAST
                                              : acs_pkg::SAMP_SHORT_LAST;

  // converter clock source; bus, half bus and alternate need no wake state
  // wait-usable sources
  assign src_tick = (clk_sel == acs_pkg::CLK_BUS) ? 1'b1 :
                    (clk_sel == acs_pkg::CLK_BUS2) ? s.half :
                    (clk_sel == acs_pkg::CLK_ALT) ? (s.alt_s2 & ~s.alt_prev) :
                    s.atick;

  acs_tick u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .clear_in (s.st == acs_pkg::ST_IDLE),
    .src_in   (src_tick),
    .div_in   (s.cfg[acs_pkg::CFG_DIV +: 2]),
    .tick_out (converter_clock)
  );

  acs_sar u_sar (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (s.sar_start),
    .step_in  (converter_clock),
    .wide_in  (mode != acs_pkg::MODE_8),
    .cmp_in   (comparator_in),
    .code_out (code),
    .done_out (sar_done)
  );

  // rounding with saturation at full scale
  assign r8 = {1'b0, code[8:1]} + {8'h00, code[0]};
  assign r10 = {1'b0, code[11:2]} + {10'h000, code[1]};
  assign res = (mode == acs_pkg::MODE_8) ? {4'h0, (r8[8] ? 8'hFF : r8[7:0])} :
               (mode == acs_pkg::MODE_10) ? {2'h0, (r10[10] ? 10'h3FF : r10[9:0])} :
               code;

  // result plus two's complement of compare value
  assign diff = {1'b0, res} + {1'b0, ~{s.cvh[3:0], s.cvl}} + 13'h0001;
  assign cmp_ok = s.compare_greater_select ? diff[12] : !diff[12];
  // difference loaded when compare is on
  assign val = s.compare_function_enable ? diff[11:0] : res;
  assign stored = (mode == acs_pkg::MODE_8) ? {8'h00, val[7:0]} : {4'h0, val};
  // high byte read and low byte pending
  assign blocked = (mode != acs_pkg::MODE_8) && s.rh_read;

  // no start in stop unless internal clock is selected
  assign can_start = !stop_mode_in || clk_sel == acs_pkg::CLK_ASYNC;
  // trigger still honoured in wait; edges ignored while busy
  assign hw_start = s.hwt && s.hw_s2 && !s.hw_prev && s.ch != acs_pkg::CH_OFF
                    && can_start;

  // register read mux
  always_comb begin
    case (addr_in)
      acs_pkg::A_SC1: rd_mux = {s.conversion_complete_flag, s.complete_interrupt_enable, s.cont, s.ch};
      acs_pkg::A_SC2: rd_mux = {s.active, s.hwt, s.compare_function_enable, s.compare_greater_select, 4'h0};
      acs_pkg::A_CFG: rd_mux = s.cfg;
      acs_pkg::A_CVH: rd_mux = s.cvh;
      acs_pkg::A_CVL: rd_mux = s.cvl;
      acs_pkg::A_RH: rd_mux = s.rh;
      acs_pkg::A_RL: rd_mux = s.rl;
      default: rd_mux = 8'h00;
    endcase
  end

  // sequencer, register side effects, synchronisers
  always_comb begin
    next_s = s;
    set_conversion_complete_flag = 1'b0;
    next_s.sar_start = 1'b0;
    next_s.atick = 1'b0;
    next_s.hw_s1 = hw_trig_in;
    next_s.hw_s2 = s.hw_s1;
    next_s.hw_prev = s.hw_s2;
    next_s.alt_s1 = alt_clk_in;
    next_s.alt_s2 = s.alt_s1;
    next_s.alt_prev = s.alt_s2;
    // half rate restarts in phase at every start from idle, so sample length is repeatable
    next_s.half = (s.st == acs_pkg::ST_IDLE) | ~s.half;
    // internal clock generator, kept alive in stop
    if (s.aen) begin
      if (s.acnt == acs_pkg::ASYNC_TICK_LAST) begin
        next_s.acnt = 4'h0;
        next_s.atick = 1'b1;
      end else begin
        next_s.acnt = s.acnt + 4'h1;
      end
    end else begin
      next_s.acnt = 4'h0;
    end
    case (s.st)
      acs_pkg::ST_IDLE: begin
        if (hw_start) begin
          next_s.st = first_state(clk_sel, s.aen);
          next_s.cnt = 8'h00;
        end
      end
      acs_pkg::ST_WARM: begin
        if (s.cnt == acs_pkg::ASYNC_START_LAST) begin
          next_s.st = acs_pkg::ST_SAMPLE;
          next_s.cnt = 8'h00;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      // ticks come from the bus domain, so a slow bus stretches them
      acs_pkg::ST_SAMPLE: begin
        if (converter_clock) begin
          if (s.cnt == samp_last) begin
            next_s.st = acs_pkg::ST_CONVERT;
            next_s.sar_start = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 8'h01;
          end
        end
      end
      // stale done of an older run is masked by the start pulse
      acs_pkg::ST_CONVERT: begin
        if (sar_done && !s.sar_start) begin
          next_s.st = acs_pkg::ST_XFER;
        end
      end
      // one bus cycle for the hand-over
      acs_pkg::ST_XFER: begin
        next_s.cnt = 8'h00;
        if (s.compare_function_enable && !cmp_ok) begin
          next_s.st = s.cont ? first_state(clk_sel, s.aen) : acs_pkg::ST_IDLE;
        end else if (blocked) begin
          next_s.st = first_state(clk_sel, s.aen);
        end else begin
          // flag set in any power mode
          next_s.rh = stored[15:8];
          next_s.rl = stored[7:0];
          next_s.conversion_complete_flag = 1'b1;
          set_conversion_complete_flag = 1'b1;
          next_s.st = s.cont ? first_state(clk_sel, s.aen) : acs_pkg::ST_IDLE;
        end
      end
      default: next_s.st = acs_pkg::ST_IDLE;
    endcase
    // reads; a flag set in the same cycle wins over the clear
    next_s.rdata = rd_in ? rd_mux : 8'h00;
    if (rd_in && addr_in == acs_pkg::A_RH && mode != acs_pkg::MODE_8) begin
      next_s.rh_read = 1'b1;
    end
    if (rd_in && addr_in == acs_pkg::A_RL) begin
      next_s.rh_read = 1'b0;
      if (!set_conversion_complete_flag) begin
        next_s.conversion_complete_flag = 1'b0;
      end
    end
    // writes; any control write aborts, results kept
    if (wr_in) begin
      case (addr_in)
        acs_pkg::A_SC1: begin
          next_s.complete_interrupt_enable = wdata_in[acs_pkg::SC1_COMPLETE_INTERRUPT_ENABLE];
          next_s.cont = wdata_in[acs_pkg::SC1_CONT];
          next_s.ch = wdata_in[4:0];
          next_s.cnt = 8'h00;
          if (!set_conversion_complete_flag) begin
            next_s.conversion_complete_flag = 1'b0;
          end
          if (wdata_in[4:0] != acs_pkg::CH_OFF && !s.hwt && can_start) begin
            next_s.st = first_state(clk_sel, s.aen);
          end else begin
            next_s.st = acs_pkg::ST_IDLE;
          end
        end
        acs_pkg::A_SC2: begin
          next_s.hwt = wdata_in[acs_pkg::SC2_HWT];
          next_s.compare_function_enable = wdata_in[acs_pkg::SC2_COMPARE_FUNCTION_ENABLE];
          next_s.compare_greater_select = wdata_in[acs_pkg::SC2_COMPARE_GREATER_SELECT];
          next_s.st = acs_pkg::ST_IDLE;
        end
        acs_pkg::A_CFG: begin
          next_s.cfg = wdata_in;
          next_s.st = acs_pkg::ST_IDLE;
        end
        acs_pkg::A_CVH: begin
          next_s.cvh = wdata_in;
          next_s.st = acs_pkg::ST_IDLE;
        end
        acs_pkg::A_CVL: begin
          next_s.cvl = wdata_in;
          next_s.st = acs_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    if (stop_mode_in && clk_sel != acs_pkg::CLK_ASYNC) begin
      next_s.st = acs_pkg::ST_IDLE;
    end
    // generator runs only when chosen and busy
    next_s.aen = next_s.st != acs_pkg::ST_IDLE
                 && next_s.cfg[acs_pkg::CFG_CLK +: 2] == acs_pkg::CLK_ASYNC;
    next_s.sampling = next_s.st == acs_pkg::ST_SAMPLE;
    next_s.active = next_s.st != acs_pkg::ST_IDLE;
    next_s.irq = next_s.conversion_complete_flag & next_s.complete_interrupt_enable;
  end

  // reset clears results and disables the channel
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.ch <= acs_pkg::CH_OFF;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign rdata_out = s.rdata;
  assign irq_out = s.irq;
  assign active_out = s.active;
  assign sample_out = s.sampling;
  assign channel_out = s.ch;
  assign async_clk_en_out = s.aen;
  assign dac_code_out = code;

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence mode_wr_s;
    wr_in && (addr_in == acs_pkg::A_SC2 || addr_in == acs_pkg::A_CFG ||
              addr_in == acs_pkg::A_CVH || addr_in == acs_pkg::A_CVL);
  endsequence
  sequence abort_s;
    (s.st != acs_pkg::ST_IDLE && s.st != acs_pkg::ST_XFER) ##1
    (s.st == acs_pkg::ST_IDLE);
  endsequence
  sequence cmp_false_s;
    s.st == acs_pkg::ST_XFER && s.compare_function_enable && !cmp_ok;
  endsequence

  mode_abort_a:
    assert property (mode_wr_s |=> s.st == acs_pkg::ST_IDLE)
    else $error("mode write did not abort");
  sc1_start_a:
    assert property (wr_in && addr_in == acs_pkg::A_SC1 && can_start && !s.hwt
      && wdata_in[4:0] != acs_pkg::CH_OFF
      |=> s.st == acs_pkg::ST_SAMPLE || s.st == acs_pkg::ST_WARM)
    else $error("control write did not restart");
  chan_off_a:
    assert property (wr_in && addr_in == acs_pkg::A_SC1
      && wdata_in[4:0] == acs_pkg::CH_OFF |=> s.st == acs_pkg::ST_IDLE && !active_out)
    else $error("disabled channel still active");
  result_hold_a:
    assert property (s.st != acs_pkg::ST_XFER |=> $stable(s.rh) && $stable(s.rl))
    else $error("result changed outside transfer");
  stop_abort_a:
    assert property (stop_mode_in && clk_sel != acs_pkg::CLK_ASYNC
      |=> s.st == acs_pkg::ST_IDLE)
    else $error("stop did not abort");
  sample_len_a:
    assert property (s.st == acs_pkg::ST_CONVERT && $past(s.st) == acs_pkg::ST_SAMPLE
      |-> $past(s.cnt) == $past(samp_last) && sample_out == 1'b0)
    else $error("wrong sample length");
  cmp_false_a:
    assert property (cmp_false_s |=> !$rose(s.conversion_complete_flag) && $stable(s.rl))
    else $error("false compare stored a result");
  cmp_sum_a:
    assert property (s.st == acs_pkg::ST_XFER && s.compare_function_enable && cmp_ok && !blocked
      |=> s.rl == $past(stored[7:0]) && s.conversion_complete_flag)
    else $error("compare difference not stored");
  blocked_a:
    assert property (s.st == acs_pkg::ST_XFER && blocked && !(s.compare_function_enable && !cmp_ok)
      |=> !$rose(s.conversion_complete_flag) && $stable(s.rh))
    else $error("blocked result was transferred");
  irq_flag_a:
    assert property ($rose(s.conversion_complete_flag) && s.complete_interrupt_enable |-> irq_out)
    else $error("interrupt missing on completion");
  abort_quiet_a:
    assert property (abort_s |-> !$rose(s.conversion_complete_flag) && !$rose(irq_out))
    else $error("abort raised completion");
  async_on_a:
    assert property (s.st == acs_pkg::ST_WARM |-> async_clk_en_out)
    else $error("internal clock off during warm-up");
endmodule // acs_conv_seq
`default_nettype wire

// ===== acs_pkg.sv
package acs_pkg;
  // register offsets on the plain port
  localparam logic [2:0] A_SC1 = 3'h0;
  localparam logic [2:0] A_SC2 = 3'h1;
  localparam logic [2:0] A_CFG = 3'h2;
  localparam logic [2:0] A_CVH = 3'h3;
  localparam logic [2:0] A_CVL = 3'h4;
  localparam logic [2:0] A_RH  = 3'h5;
  localparam logic [2:0] A_RL  = 3'h6;
  // field positions
  localparam int SC1_CONVERSION_COMPLETE_FLAG  = 7;
  localparam int SC1_COMPLETE_INTERRUPT_ENABLE  = 6;
  localparam int SC1_CONT  = 5;
  localparam int SC2_ACT   = 7;
  localparam int SC2_HWT   = 6;
  localparam int SC2_COMPARE_FUNCTION_ENABLE  = 5;
  localparam int SC2_COMPARE_GREATER_SELECT = 4;
  localparam int CFG_DIV   = 5;
  localparam int CFG_LSMP  = 4;
  localparam int CFG_MODE  = 2;
  localparam int CFG_CLK   = 0;
  // field encodings and reset values
  localparam logic [4:0] CH_OFF    = 5'h1F;
  localparam logic [1:0] MODE_8    = 2'h0;
  localparam logic [1:0] MODE_12   = 2'h1;
  localparam logic [1:0] MODE_10   = 2'h2;
  localparam logic [1:0] CLK_BUS   = 2'h0;
  localparam logic [1:0] CLK_BUS2  = 2'h1;
  localparam logic [1:0] CLK_ALT   = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [7:0] REG_RST   = 8'h00;
  // timing
  localparam int CLK_NS = 25;
  localparam int ASYNC_START_NS = 5000;
  localparam int ASYNC_START_CYC = ASYNC_START_NS / CLK_NS;
  localparam logic [7:0] ASYNC_START_LAST = 8'(ASYNC_START_CYC - 1);
  localparam logic [3:0] ASYNC_TICK_LAST = 4'h7;
  localparam logic [7:0] SAMP_SHORT = 8'h04;
  localparam logic [7:0] SAMP_LONG = 8'h18;
  localparam logic [7:0] SAMP_SHORT_LAST = SAMP_SHORT - 8'h01;
  localparam logic [7:0] SAMP_LONG_LAST = SAMP_LONG - 8'h01;
  localparam logic [3:0] SAR_TOP_12 = 4'hB;
  localparam logic [3:0] SAR_TOP_9 = 4'h8;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_WARM    = 3'h1,
    ST_SAMPLE  = 3'h2,
    ST_CONVERT = 3'h3,
    ST_XFER    = 3'h4
  } acs_state_t;
endpackage

// ===== acs_tick.sv
`timescale 1ns/10ps
`default_nettype none
// converter clock as a tick: source divided by 1, 2, 4 or 8
module acs_tick (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       clear_in,
  input  wire logic       src_in,
  input  wire logic [1:0] div_in,
  output logic            tick_out
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } acs_tick_t;
  acs_tick_t  s;
  acs_tick_t  next_s;
  logic [2:0] last;

  // count source ticks, restart phase while idle
  always_comb begin
    last = 3'((4'h1 << div_in) - 4'h1);
    next_s = s;
    next_s.tick = 1'b0;
    if (clear_in) begin
      next_s.cnt = 3'h0;
    end else if (src_in) begin
      if (s.cnt >= last) begin
        next_s.cnt = 3'h0;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;
endmodule // acs_tick
`default_nettype wire

// ===== acs_sar.sv
`timescale 1ns/10ps
`default_nettype none
// successive approximation register, one bit per converter tick
module acs_sar (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        step_in,
  input  wire logic        wide_in,
  input  wire logic        cmp_in,
  output logic [11:0]      code_out,
  output logic             done_out
);
  typedef struct packed {
    logic [11:0] code;
    logic [3:0]  idx;
    logic        busy;
    logic        done;
  } acs_sar_t;
  acs_sar_t s;
  acs_sar_t next_s;

  // trial bit kept when the input is at or above it
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start_in) begin
      next_s.busy = 1'b1;
      next_s.idx = wide_in ? acs_pkg::SAR_TOP_12 : acs_pkg::SAR_TOP_9;
      next_s.code = 12'h001 << next_s.idx;
    end else if (s.busy && step_in) begin
      if (!cmp_in) begin
        next_s.code[s.idx] = 1'b0;
      end
      if (s.idx == 4'h0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.idx = 4'(s.idx - 4'h1);
        next_s.code[next_s.idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign code_out = s.code;
  assign done_out = s.done;
endmodule // acs_sar
`default_nettype wire

// ===== adc_conversion_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module adc_conversion_sequencer_tb_top;
  logic        clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic        hw_trig_in = 0, alt_clk_in = 0, stop_mode_in = 0;
  logic [2:0]  addr_in = 3'h0;
  logic [7:0]  wdata_in = 8'h00, rdata_out, d;
  logic        irq_out, active_out, sample_out, async_clk_en_out, comparator_in, gt, hit;
  logic [4:0]  channel_out;
  logic [11:0] dac_code_out, vin = 12'h000, last = 12'h000, r, cv, pv;
  logic [7:0]  cf[4] = '{8'h04, 8'h05, 8'h06, 8'h14};
  int          bd[4] = '{28, 51, 51, 48};
  // sampling cycles: ticks times period, plus 2 less one period for the first tick
  int          kx[4] = '{5, 8, 0, 25};
  int          fails = 0, checks_done = 0, n, k;

  // bus clock, alternate source at half rate
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) alt_clk_in <= ~alt_clk_in;
  // ideal analog comparator against the trial code
  assign comparator_in = (vin >= dac_code_out);

  acs_conv_seq i_acs_conv_seq (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .hw_trig_in(hw_trig_in),
    .alt_clk_in(alt_clk_in), .stop_mode_in(stop_mode_in), .comparator_in(comparator_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .active_out(active_out),
    .sample_out(sample_out), .channel_out(channel_out),
    .async_clk_en_out(async_clk_en_out), .dac_code_out(dac_code_out));

  // case equality so unknowns never match
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  // one-cycle strobes, a gap edge between calls
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  // high byte first so the pair stays coherent
  task res(output logic [11:0] v);
    logic [7:0] h, l;
    rd(acs_pkg::A_RH, h);
    rd(acs_pkg::A_RL, l);
    v = {h[3:0], l};
  endtask

  // bounded wait, also counts sampling cycles
  task wait_irq(input int mx);
    n = 0;
    k = 0;
    #1;
    while (irq_out !== 1'b1 && n < mx) begin
      if (sample_out === 1'b1) k++;
      @(posedge clk_in);
      #1 n++;
    end
  endtask

  task print_verdict;
    $display("checks %0d, fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog, well past the expected run length
  initial begin
    #500000;
    fails++;
    print_verdict;
  end

  initial begin
    void'($urandom(51161));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    // reset values, unmapped index reads zero
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      `CHK(d, (a == 0) ? 8'h1F : 8'h00);
    end
    // timing per bus, half bus and alternate source, sample length per bus source and sample select
    for (int i = 0; i < 4; i++) begin
      wr(acs_pkg::A_CFG, cf[i]);
      vin = 12'($urandom);
      wr(acs_pkg::A_SC1, 8'h41);
      wait_irq(bd[i]);
      `CHK(irq_out, 1);
      if (i != 2) `CHK(k, kx[i]);
      `CHK(active_out, 0);
      res(r);
      `CHK(r, vin);
      last = vin;
    end
    // writes to the mode registers abort, results kept
    for (int a = 1; a < 5; a++) begin
      wr(acs_pkg::A_CFG, 8'h04);
      vin = 12'($urandom);
      wr(acs_pkg::A_SC1, 8'h41);
      repeat (3) @(posedge clk_in);
      wr(a[2:0], (a == 2) ? 8'h04 : 8'h00);
      wait_irq(60);
      `CHK(irq_out, 0);
      `CHK(active_out, 0);
      res(r);
      `CHK(r, last);
    end
    // control one rewrite restarts on the new channel
    wr(acs_pkg::A_SC1, 8'h41);
    repeat (5) @(posedge clk_in);
    vin = 12'($urandom);
    wr(acs_pkg::A_SC1, 8'h42);
    wait_irq(28);
    `CHK(channel_out, 2);
    res(r);
    `CHK(r, vin);
    last = vin;
    // all-ones channel stops the converter
    wr(acs_pkg::A_SC1, 8'h41);
    wr(acs_pkg::A_SC1, 8'h5F);
    wait_irq(40);
    `CHK(active_out, 0);
    // compare both directions, equal values at the edge
    for (int i = 0; i < 6; i++) begin
      vin = 12'($urandom);
      cv = (i < 2) ? vin : 12'($urandom);
      gt = i[0];
      hit = gt ? (vin >= cv) : (vin < cv);
      wr(acs_pkg::A_CVH, {4'h0, cv[11:8]});
      wr(acs_pkg::A_CVL, cv[7:0]);
      wr(acs_pkg::A_SC2, gt ? 8'h30 : 8'h20);
      wr(acs_pkg::A_SC1, 8'h41);
      wait_irq(40);
      `CHK(irq_out, hit);
      res(r);
      `CHK(r, hit ? 12'(vin - cv) : last);
      if (hit) last = 12'(vin - cv);
    end
    wr(acs_pkg::A_SC2, 8'h00);
    // stop on a bus-derived clock aborts
    vin = 12'($urandom);
    wr(acs_pkg::A_SC1, 8'h41);
    stop_mode_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    stop_mode_in <= 1'b0;
    wait_irq(40);
    `CHK(irq_out, 0);
    res(r);
    `CHK(r, last);
    // internal clock keeps converting through stop
    // no result read pending before stop
    wr(acs_pkg::A_CFG, 8'h07);
    vin = 12'($urandom);
    wr(acs_pkg::A_SC1, 8'h41);
    stop_mode_in <= 1'b1;
    #1 `CHK(async_clk_en_out, 1);
    wait_irq(389);
    `CHK(irq_out, 1);
    @(posedge clk_in);
    stop_mode_in <= 1'b0;
    res(r);
    `CHK(r, vin);
    // continuous: repeat interval, then a blocked transfer
    wr(acs_pkg::A_CFG, 8'h04);
    wr(acs_pkg::A_SC1, 8'h61);
    wait_irq(28);
    rd(acs_pkg::A_RL, d);
    @(posedge clk_in);
    wait_irq(20);
    `CHK(irq_out, 1);
    rd(acs_pkg::A_RL, d);
    rd(acs_pkg::A_RH, d);
    pv = vin;
    vin = ~vin;
    wait_irq(45);
    `CHK(irq_out, 0);
    rd(acs_pkg::A_RL, d);
    `CHK(d, pv[7:0]);
    wr(acs_pkg::A_SC1, 8'h1F);
    // hardware trigger starts, software write does not
    wr(acs_pkg::A_SC2, 8'h40);
    vin = 12'($urandom);
    wr(acs_pkg::A_SC1, 8'h41);
    #1 `CHK(active_out, 0);
    @(posedge clk_in);
    hw_trig_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    hw_trig_in <= 1'b0;
    wait_irq(40);
    `CHK(irq_out, 1);
    res(r);
    `CHK(r, vin);
    print_verdict;
  end
endmodule // adc_conversion_sequencer_tb_top
`default_nettype wire
